//--- inc/pcs_pkg.sv
package pcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_START_INDEX = 8'h04;
  localparam logic [7:0] OFS_REMAINING = 8'h08;
  localparam logic [7:0] OFS_POINT_INDEX = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_ARRAY_ADDR = 8'h18;
  localparam logic [7:0] OFS_ARRAY_DATA = 8'h1c;
  // control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_CONTINUOUS_BIT = 1;
  localparam int CTL_AUTO_CAPTURE_BIT = 2;
  localparam int CTL_POLARITY_NC_BIT = 3;
  localparam int CTL_WIDTH = 4;
  localparam logic [3:0] CTL_RESET = 4'h0;
  // status bits
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_ZERO_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESPONSE_TIME_NS = 5000;
  localparam int RESPONSE_CYCLES = RESPONSE_TIME_NS / CLK_PERIOD_NS;
  localparam int PULSE_TIME_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_LOAD = 4'b0010,
    SEQ_WATCH = 4'b0100,
    SEQ_MATCHED = 4'b1000
  } pcs_state_e;
endpackage

//--- inc/pcs_pulse_if.sv
`timescale 1ns/1ns
interface pcs_pulse_if;
  logic fire;
  logic busy;
  logic polarity_nc;
  logic level;
  modport seq (output fire, output polarity_nc, input busy, input level);
  modport gen (input fire, input polarity_nc, output busy, output level);
endinterface

//--- logic/pcs_compare_seq.sv
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - first point comes from start index
// - points are signed 32-bit pulse counts
// - match on crossing in either direction
// - last point at start plus count minus one
// - enable bit starts at first point
// - one output pulse per matched point
// - count decrements per match, stops at zero; a continuous-mode last match reloads the start count instead
// - non-continuous end clears enable bit
// - continuous mode restarts at first point
// - continuous mode keeps enable bit set
// - auto-capture enables capture after last point
// - enable with zero count clears enable
// - output on fourth output within 5 us
// - output polarity selectable open or closed
module pcs_compare_seq
  import pcs_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CE,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // position source
  input wire logic signed [31:0] SOURCE_POSITION,
  // outputs
  output logic COMPARE_PULSE_OUTPUT,
  output logic CAPTURE_ENABLE,
  output logic IRQ
);
  logic rst_s1, rst_n;
  logic [31:0] data_array [DEPTH];
  logic [CTL_WIDTH-1:0] compare_control;
  logic [AW-1:0] compare_start_index, point_index, array_addr;
  logic [AW:0] compare_remaining_count, original_count;
  logic [IRQ_WIDTH-1:0] irq_status, irq_mask, irq_event;
  logic signed [31:0] compare_value, prev_pos;
  pcs_state_e state;
  logic bus_req, wr, rd, clr_status_rd;
  logic match;
  logic [AW-1:0] next_index;
  logic seq_end, last_point;
  pcs_pulse_if pif ();

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  // reset release
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = bus_req && WB_WE_I;
  assign rd = bus_req && !WB_WE_I;
  assign clr_status_rd = rd && hit(WB_ADR_I, OFS_IRQ_STATUS);

  // bus ack one cycle after request
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
    end else if (CE) begin
      WB_ACK_O <= bus_req;
    end
  end

  // read data
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE && rd) begin
      case (WB_ADR_I)
        OFS_CONTROL: WB_DAT_O <= 32'(compare_control);
        OFS_START_INDEX: WB_DAT_O <= 32'(compare_start_index);
        OFS_REMAINING: WB_DAT_O <= 32'(compare_remaining_count);
        OFS_POINT_INDEX: WB_DAT_O <= 32'(point_index);
        OFS_IRQ_STATUS: WB_DAT_O <= 32'(irq_status);
        OFS_IRQ_MASK: WB_DAT_O <= 32'(irq_mask);
        OFS_ARRAY_ADDR: WB_DAT_O <= 32'(array_addr);
        OFS_ARRAY_DATA: WB_DAT_O <= data_array[array_addr];
        default: WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // data array and its pointer
  always_ff @(posedge REF_CLK) begin
    if (CE && wr && hit(WB_ADR_I, OFS_ARRAY_DATA)) begin
      data_array[array_addr] <= merge_bytes(data_array[array_addr], WB_DAT_I, WB_SEL_I);
    end
  end
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      array_addr <= '0;
    end else if (CE && wr && hit(WB_ADR_I, OFS_ARRAY_ADDR) && WB_SEL_I[0]) begin
      array_addr <= WB_DAT_I[AW-1:0];
    end else if (CE && bus_req && hit(WB_ADR_I, OFS_ARRAY_DATA)) begin
      array_addr <= array_addr + 1'b1;
    end
  end

  // plain settings
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      compare_start_index <= '0;
      irq_mask <= '0;
    end else if (CE && wr && WB_SEL_I[0]) begin
      if (hit(WB_ADR_I, OFS_START_INDEX)) begin
        compare_start_index <= WB_DAT_I[AW-1:0];
      end
      if (hit(WB_ADR_I, OFS_IRQ_MASK)) begin
        irq_mask <= WB_DAT_I[IRQ_WIDTH-1:0];
      end
    end
  end

  // matching: crossing detect in either direction
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prev_pos <= 32'sh0000_0000;
    end else if (CE) begin
      prev_pos <= SOURCE_POSITION;
    end
  end
  assign match = (state == SEQ_WATCH) && !pif.busy &&
                 (((prev_pos < compare_value) && (SOURCE_POSITION >= compare_value)) ||
                  ((prev_pos > compare_value) && (SOURCE_POSITION <= compare_value)) ||
                  (SOURCE_POSITION == compare_value));
  assign seq_end = compare_remaining_count == (AW+1)'(1);
  assign next_index = point_index + 1'b1;

  // sequencer
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= SEQ_IDLE;
      point_index <= '0;
      compare_value <= 32'sh0000_0000;
      original_count <= '0;
      last_point <= 1'b0;
    end else if (CE) begin
      case (state)
        SEQ_IDLE: begin
          if (compare_control[CTL_ENABLE_BIT] && compare_remaining_count != '0) begin
            point_index <= compare_start_index;
            original_count <= compare_remaining_count;
            state <= SEQ_LOAD;
          end
        end
        SEQ_LOAD: begin
          compare_value <= data_array[point_index];
          state <= SEQ_WATCH;
        end
        SEQ_WATCH: begin
          if (!compare_control[CTL_ENABLE_BIT]) begin
            state <= SEQ_IDLE;
          end else if (match) begin
            last_point <= seq_end;
            state <= SEQ_MATCHED;
          end
        end
        SEQ_MATCHED: begin
          if (last_point) begin
            // last point at start + count - 1 was just used
            if (compare_control[CTL_CONTINUOUS_BIT]) begin
              point_index <= compare_start_index;
              state <= SEQ_LOAD;
            end else if (!pif.busy) begin
              // single run ends once the last pulse is complete
              state <= SEQ_IDLE;
            end
          end else begin
            point_index <= next_index;
            state <= SEQ_LOAD;
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  // control and count registers, hardware wins over software
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      compare_control <= CTL_RESET;
      compare_remaining_count <= '0;
    end else if (CE) begin
      if (wr && hit(WB_ADR_I, OFS_CONTROL) && WB_SEL_I[0]) begin
        compare_control <= WB_DAT_I[CTL_WIDTH-1:0];
      end
      if (wr && hit(WB_ADR_I, OFS_REMAINING) && WB_SEL_I[0]) begin
        compare_remaining_count <= WB_DAT_I[AW:0];
      end
      if (state == SEQ_IDLE && compare_control[CTL_ENABLE_BIT] &&
          compare_remaining_count == '0) begin
        compare_control[CTL_ENABLE_BIT] <= 1'b0;
      end
      if (match) begin
        if (seq_end && compare_control[CTL_CONTINUOUS_BIT]) begin
          compare_remaining_count <= original_count;
        end else begin
          compare_remaining_count <= compare_remaining_count - 1'b1;
        end
      end
      if (state == SEQ_MATCHED && last_point && !pif.busy &&
          !compare_control[CTL_CONTINUOUS_BIT]) begin
        compare_control[CTL_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // capture handover
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CAPTURE_ENABLE <= 1'b0;
    end else if (CE) begin
      if (!compare_control[CTL_AUTO_CAPTURE_BIT]) begin
        CAPTURE_ENABLE <= 1'b0;
      end else if (match && seq_end) begin
        CAPTURE_ENABLE <= 1'b1;
      end
    end
  end

  // interrupts: sticky, cleared by read, set wins
  assign irq_event = {state == SEQ_IDLE && compare_control[CTL_ENABLE_BIT] &&
                      compare_remaining_count == '0, match && seq_end, match};
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (CE) begin
      irq_status <= (clr_status_rd ? '0 : irq_status) | irq_event;
    end
  end
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // pulse output
  assign pif.fire = match;
  assign pif.polarity_nc = compare_control[CTL_POLARITY_NC_BIT];
  assign COMPARE_PULSE_OUTPUT = pif.level;

  pcs_pulse_gen u_pulse (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .ce(CE),
    .pif(pif)
  );

  pulse_follows_match_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && match) |=> (COMPARE_PULSE_OUTPUT != compare_control[CTL_POLARITY_NC_BIT]))
    else $error("no pulse after match");
  count_decrement_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && match && !seq_end) |=>
      compare_remaining_count == $past(compare_remaining_count) - 1'b1)
    else $error("count did not decrement");
  zero_count_clear_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_IDLE && compare_control[CTL_ENABLE_BIT] &&
     compare_remaining_count == '0 && !wr) |=> !compare_control[CTL_ENABLE_BIT])
    else $error("enable not cleared at zero count");
  single_end_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_MATCHED && last_point && !pif.busy &&
     !compare_control[CTL_CONTINUOUS_BIT]) |=> !compare_control[CTL_ENABLE_BIT])
    else $error("enable stays set after last point");
  continuous_keep_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && match && seq_end && compare_control[CTL_CONTINUOUS_BIT] && !wr) |=>
      compare_control[CTL_ENABLE_BIT] && compare_remaining_count == $past(original_count))
    else $error("continuous mode lost enable");
  start_index_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_IDLE && compare_control[CTL_ENABLE_BIT] &&
     compare_remaining_count != '0) |=> point_index == $past(compare_start_index))
    else $error("start index not loaded");
  capture_after_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && match && seq_end && compare_control[CTL_AUTO_CAPTURE_BIT]) |=> CAPTURE_ENABLE)
    else $error("capture not enabled");
  advance_index_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_MATCHED && !last_point) |=>
      point_index == $past(point_index) + 1'b1)
    else $error("index not advanced");
  response_time_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && match) |-> ##[1:2] COMPARE_PULSE_OUTPUT != compare_control[CTL_POLARITY_NC_BIT])
    else $error("pulse too late");
  last_count_zero_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && match && seq_end && !compare_control[CTL_CONTINUOUS_BIT]) |=>
      compare_remaining_count == '0)
    else $error("count not zero after last point");
  enable_held_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_MATCHED && pif.busy && !wr && compare_control[CTL_ENABLE_BIT]) |=>
      compare_control[CTL_ENABLE_BIT])
    else $error("enable cleared while pulse active");
  restart_first_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_MATCHED && last_point && compare_control[CTL_CONTINUOUS_BIT]) |=>
      state == SEQ_LOAD && point_index == $past(compare_start_index))
    else $error("continuous run did not restart");
  zero_status_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_IDLE && compare_control[CTL_ENABLE_BIT] &&
     compare_remaining_count == '0) |=> irq_status[IRQ_ZERO_BIT])
    else $error("zero count not flagged");
  idle_level_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && !pif.busy && !match) |=>
      COMPARE_PULSE_OUTPUT == $past(compare_control[CTL_POLARITY_NC_BIT]))
    else $error("output not at idle level");
  load_point_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (CE && state == SEQ_LOAD) |=> compare_value == $past(data_array[point_index]))
    else $error("compare value not loaded");
endmodule

//--- logic/pcs_pulse_gen.sv
`timescale 1ns/1ns
module pcs_pulse_gen
  import pcs_pkg::*;
#(
  parameter int WIDTH_CYCLES = PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // pulse request
  pcs_pulse_if.gen pif
);
  logic [15:0] cnt;
  logic active;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      active <= 1'b0;
    end else if (ce) begin
      if (pif.fire && !active) begin
        active <= 1'b1;
        cnt <= 16'(WIDTH_CYCLES - 1);
      end else if (active) begin
        if (cnt == 16'h0000) begin
          active <= 1'b0;
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
    end
  end
  // contact type selects idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pif.level <= 1'b0;
    end else if (ce) begin
      pif.level <= ((pif.fire && !active) || (active && cnt != 16'h0000)) ^ pif.polarity_nc;
    end
  end
  assign pif.busy = active;
endmodule

//--- verif/pcs_compare_seq_bench.sv
`timescale 1ns/1ns
module pcs_compare_seq_bench;
  import pcs_pkg::*;
  logic clk, nrst, ce, cyc, stb, we, ack, pulse_out, cap_en, irq;
  logic [7:0] adr;
  logic [3:0] sel, lanes;
  logic [31:0] dat_i, dat_o, rd, w0, w1;
  logic signed [31:0] target, pos;
  logic idle, watch, act;
  int miscompares, checked, seed, start, len;
  int pos_q[$];
  int pt[3];

  pcs_compare_seq dut (.REF_CLK(clk), .NRST(nrst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SOURCE_POSITION(pos), .COMPARE_PULSE_OUTPUT(pulse_out),
    .CAPTURE_ENABLE(cap_en), .IRQ(irq));
  pcs_position_source src (.clk(clk), .rst_n(nrst), .target(target), .position(pos));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lane_mix(input logic [31:0] a, input logic [31:0] b,
                                           input logic [3:0] s);
    return {s[3] ? b[31:24] : a[31:24], s[2] ? b[23:16] : a[23:16],
            s[1] ? b[15:8] : a[15:8], s[0] ? b[7:0] : a[7:0]};
  endfunction

  task final_report;
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // pulse monitor: start position and width of every pulse
  always @(negedge clk) begin
    if (watch && pulse_out !== idle) begin
      if (!act) pos_q.push_back(pos);
      act = 1;
      len++;
    end else begin
      if (act) check(len, PULSE_CYCLES);
      act = 0;
      len = 0;
    end
  end

  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= lanes;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) miscompares++;
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    check(rd, e);
  endtask

  task go(input int t);
    int n;
    n = 0;
    @(posedge clk);
    target <= t;
    @(negedge clk);
    while (pos != t && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) miscompares++;
    repeat (4) @(negedge clk);
  endtask

  task load(input int s, input int n);
    wb(OFS_ARRAY_ADDR, 1'b1, s);
    for (int i = 0; i < n; i++) begin
      wb(OFS_ARRAY_DATA, 1'b1, pt[i]);
    end
    wb(OFS_REMAINING, 1'b1, n);
    wb(OFS_START_INDEX, 1'b1, s);
    pos_q.delete();
  endtask

  task pulses(input int n, input int dir);
    int d;
    check(pos_q.size(), n);
    for (int i = 0; i < n && i < pos_q.size(); i++) begin
      d = (pos_q[i] - pt[i]) * dir;
      check(d >= 0 && d <= RESPONSE_CYCLES, 1);
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    final_report;
  end

  initial begin
    seed = 32'h4bb1;
    {nrst, cyc, stb, we, adr, sel, dat_i, target, idle, watch, act} = '0;
    ce = 1'b1;
    lanes = 4'hf;
    {miscompares, checked, len} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    rd_chk(OFS_CONTROL, 0);
    rd_chk(8'h40, 0);
    // byte lanes on one array word, pointer auto-increment
    w0 = $random(seed);
    w1 = $random(seed);
    wb(OFS_ARRAY_ADDR, 1'b1, 32'h28);
    wb(OFS_ARRAY_DATA, 1'b1, w0);
    wb(OFS_ARRAY_ADDR, 1'b1, 32'h28);
    lanes = 4'h6;
    wb(OFS_ARRAY_DATA, 1'b1, w1);
    lanes = 4'hf;
    wb(OFS_ARRAY_ADDR, 1'b1, 32'h28);
    rd_chk(OFS_ARRAY_DATA, lane_mix(w0, w1, 4'h6));
    rd_chk(OFS_ARRAY_ADDR, 32'h29);
    // clock enable low holds a request unanswered
    ce <= 1'b0;
    fork
      wb(OFS_START_INDEX, 1'b1, 32'h5);
      begin
        repeat (8) begin
          @(negedge clk);
          check(ack, 1'b0);
        end
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    rd_chk(OFS_START_INDEX, 32'h5);
    // non-continuous run, rising travel
    start = $random(seed) & 31;
    pt[0] = 200 + ($random(seed) & 255);
    pt[1] = pt[0] + 200 + ($random(seed) & 255);
    pt[2] = pt[1] + 200;
    load(start, 3);
    wb(OFS_IRQ_MASK, 1'b1, 32'h2);
    watch = 1;
    wb(OFS_CONTROL, 1'b1, 32'h1);
    rd_chk(OFS_POINT_INDEX, start);
    go(pt[0] + 120);
    rd_chk(OFS_REMAINING, 2);
    rd_chk(OFS_POINT_INDEX, start + 1);
    go(pt[2] + 150);
    pulses(3, 1);
    rd_chk(OFS_REMAINING, 0);
    rd_chk(OFS_CONTROL, 0);
    check(irq, 1);
    rd_chk(OFS_IRQ_STATUS, 32'h3);
    rd_chk(OFS_IRQ_STATUS, 0);
    repeat (3) @(negedge clk);
    check(irq, 0);
    // continuous run, closed contact, falling travel, last array slots
    watch = 0;
    pt[0] = -100 - ($random(seed) & 255);
    pt[1] = pt[0] - 250;
    load(62, 2);
    wb(OFS_CONTROL, 1'b1, 32'hb);
    repeat (3) @(negedge clk);
    check(pulse_out, 1);
    idle = 1;
    watch = 1;
    go(pt[1] - 150);
    pulses(2, -1);
    rd_chk(OFS_CONTROL, 32'hb);
    rd_chk(OFS_REMAINING, 2);
    pos_q.delete();
    go(pt[0] + 150);
    pulses(1, 1);
    watch = 0;
    wb(OFS_CONTROL, 1'b1, 32'h0);
    repeat (3) @(negedge clk);
    idle = 0;
    check(pulse_out, 0);
    // single point with capture hand-over
    pt[0] = pos + 200;
    load(0, 1);
    watch = 1;
    wb(OFS_CONTROL, 1'b1, 32'h5);
    go(pt[0] + 150);
    pulses(1, 1);
    check(cap_en, 1);
    rd_chk(OFS_CONTROL, 32'h4);
    wb(OFS_CONTROL, 1'b1, 32'h0);
    repeat (3) @(negedge clk);
    check(cap_en, 0);
    // enable with nothing to compare
    wb(OFS_IRQ_STATUS, 1'b0, 32'h0);
    wb(OFS_REMAINING, 1'b1, 32'h0);
    pos_q.delete();
    wb(OFS_CONTROL, 1'b1, 32'h1);
    repeat (3) @(negedge clk);
    rd_chk(OFS_CONTROL, 0);
    check(pos_q.size(), 0);
    wb(OFS_IRQ_MASK, 1'b1, 32'h4);
    @(negedge clk);
    check(irq, 1);
    rd_chk(OFS_IRQ_STATUS, 32'h4);
    @(negedge clk);
    check(irq, 0);
    final_report;
  end
endmodule

//--- verif/pcs_position_source.sv
`timescale 1ns/1ns
module pcs_position_source (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // motion command
  input wire logic signed [31:0] target,
  // axis position
  output logic signed [31:0] position
);
  // one pulse per cycle toward target, either direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      position <= '0;
    end else if (position < target) begin
      position <= position + 1;
    end else if (position > target) begin
      position <= position - 1;
    end
  end
endmodule
